// File: shared/spsa_params.svh
// Register map, field positions, reset values and counts of the reference pulse control block
`ifndef SPSA_PARAMS_SVH
`define SPSA_PARAMS_SVH
`define SPSA_ADDR_W 13
`define SPSA_OFF_PULSE 13'h005a
`define SPSA_OFF_TRIG 13'h005b
`define SPSA_OFF_BEAT_LO 13'h005c
`define SPSA_OFF_BEAT_HI 13'h005d
`define SPSA_OFF_INPUT 13'h0064
`define SPSA_OFF_DELAY 13'h0065
`define SPSA_OFF_MASK 13'h0071
`define SPSA_OFF_ID_LO 13'h0078
`define SPSA_OFF_ID_MID 13'h0079
`define SPSA_OFF_ID_HI 13'h007a
`define SPSA_OFF_ALARM_RB 13'h007b
`define SPSA_OFF_STATUS_RB 13'h007d
`define SPSA_BIT_REALIGN 2
`define SPSA_BIT_POLARITY 0
`define SPSA_BIT_HALVE 1
`define SPSA_BIT_LOWFREQ 0
`define SPSA_BIT_DLY_LP 0
`define SPSA_BIT_M_SYNCREQ 4
`define SPSA_BIT_M_PHASE 2
`define SPSA_BIT_M_ALIGN 1
`define SPSA_RST_MODE 3'h0
`define SPSA_RST_TRIG 8'h04
`define SPSA_RST_BEAT 12'h100
`define SPSA_RST_BYTE 8'h00
`define SPSA_BURST_1 3'h1
`define SPSA_BURST_2 3'h2
`define SPSA_BURST_4 3'h3
`define SPSA_BURST_8 3'h4
`define SPSA_BURST_16A 3'h5
`define SPSA_BURST_16B 3'h6
`define SPSA_INSTR_BITS 5'h10
`define SPSA_FRAME_BITS 5'h18
`endif

// File: shared/spsa_pkg.sv
// Types shared by the reference pulse control block
package spsa_pkg;
	typedef logic [2:0] spsa_burst_sel_t;
	typedef logic [11:0] spsa_beat_t;
	typedef enum logic [1:0] {PG_IDLE, PG_RUN, PG_HOLD} spsa_pg_state_t;
	localparam spsa_burst_sel_t SPSA_MODE_LEVEL = 3'h0;
	localparam spsa_burst_sel_t SPSA_MODE_CONT = 3'h7;
endpackage

// File: shared/spsa_reg_if.sv
// Register access carrier between the serial port and the register file
`timescale 1ns/1ps
`default_nettype none
interface spsa_reg_if;
	logic [12:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr;
	modport port (output addr, output wdata, output wr, input rdata);
	modport regs (input addr, input wdata, input wr, output rdata);
endinterface
`default_nettype wire

// File: verilog/spsa_serial_port.sv
// Three-wire serial control port: 16-bit instruction then one data byte
`timescale 1ns/1ps
`default_nettype none
`include "spsa_params.svh"
module spsa_serial_port (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk_i,
	input wire logic sen_n_i,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe,
	spsa_reg_if.port bus
);
	import spsa_pkg::*;
	logic [2:0] s1_r, s2_r;
	logic sclk_d_r;
	logic [4:0] cnt_r;
	logic [15:0] sh_r;
	logic [7:0] dout_r;
	logic rd_r;
	// Pins cross in through two flops; the serial clock must be far slower than clk
	wire sclk_s = s2_r[0];
	wire sen_n_s = s2_r[1];
	wire rise = sclk_s & ~sclk_d_r;
	wire fall = ~sclk_s & sclk_d_r;
	wire [15:0] sh_nxt = {sh_r[14:0], s2_r[2]};
	wire rd_phase = rd_r & (cnt_r >= `SPSA_INSTR_BITS) & (cnt_r < `SPSA_FRAME_BITS);
	assign bus.addr = sh_r[28-16:0];
	always_ff @(posedge clk) begin
		s1_r <= {sdio_i, sen_n_i, sclk_i};
		s2_r <= s1_r;
		sclk_d_r <= sclk_s;
		bus.wr <= 1'b0;
		if (!rst_n || sen_n_s) begin
			cnt_r <= 5'h00;
			rd_r <= 1'b0;
			sdio_o <= 1'b0;
			sdio_oe <= 1'b0;
			if (!rst_n) begin
				s1_r <= 3'h2;
				s2_r <= 3'h2;
				sh_r <= 16'h0000;
				dout_r <= 8'h00;
				bus.wdata <= 8'h00;
				bus.wr <= 1'b0;
			end
		end else if (rise && cnt_r < `SPSA_FRAME_BITS) begin
			cnt_r <= cnt_r + 5'h01;
			if (cnt_r < `SPSA_INSTR_BITS)
				sh_r <= sh_nxt;
			if (cnt_r == `SPSA_INSTR_BITS - 5'h01)
				rd_r <= sh_nxt[15];
			if (cnt_r >= `SPSA_INSTR_BITS)
				bus.wdata <= {bus.wdata[6:0], s2_r[2]};
			if (cnt_r == `SPSA_FRAME_BITS - 5'h01 && !rd_r)
				bus.wr <= 1'b1;
			if (cnt_r == `SPSA_INSTR_BITS - 5'h01)
				dout_r <= 8'h00;
		end else if (fall) begin
			sdio_oe <= rd_phase;
			if (rd_phase) begin
				sdio_o <= (cnt_r == `SPSA_INSTR_BITS) ? bus.rdata[7] : dout_r[7];
				dout_r <= (cnt_r == `SPSA_INSTR_BITS) ? {bus.rdata[6:0], 1'b0} : {dout_r[6:0], 1'b0};
			end
		end
	end
endmodule
`default_nettype wire

// File: verilog/spsa_pulse_gen.sv
// Reference pulse generator: level, finite burst or continuous, stepped on the beat
`timescale 1ns/1ps
`default_nettype none
`include "spsa_params.svh"
module spsa_pulse_gen (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic beat,
	input wire spsa_pkg::spsa_burst_sel_t mode,
	input wire logic req,
	output logic pulse_o,
	output logic busy_o
);
	import spsa_pkg::*;
	spsa_pg_state_t st_r;
	logic req_d_r;
	logic [5:0] left_r;
	wire req_rise = req & ~req_d_r;
	wire is_level = (mode == SPSA_MODE_LEVEL);
	wire is_cont = (mode == SPSA_MODE_CONT);
	wire [5:0] edges = (mode == `SPSA_BURST_1) ? 6'h02 : (mode == `SPSA_BURST_2) ? 6'h04 :
		(mode == `SPSA_BURST_4) ? 6'h08 : (mode == `SPSA_BURST_8) ? 6'h10 : 6'h20;
	// Level and continuous runs end only on a low phase, so no runt pulse leaves
	wire keep = is_cont | (is_level & req);
	wire last = ~is_level & ~is_cont & (left_r == 6'h01);
	always_ff @(posedge clk) begin
		req_d_r <= req;
		if (!rst_n) begin
			st_r <= PG_IDLE;
			pulse_o <= 1'b0;
			busy_o <= 1'b0;
			left_r <= 6'h00;
			req_d_r <= 1'b0;
		end else begin
			unique case (st_r)
				PG_IDLE: begin
					if (keep || (req_rise && !is_level)) begin
						st_r <= PG_RUN;
						busy_o <= 1'b1;
						left_r <= edges;
					end
				end
				PG_RUN: begin
					if (beat) begin
						if ((is_level || is_cont) && !keep && !pulse_o) begin
							st_r <= PG_IDLE;
							busy_o <= 1'b0;
						end else begin
							pulse_o <= ~pulse_o;
							left_r <= left_r - 6'h01;
							if (last) begin
								st_r <= PG_HOLD;
								busy_o <= 1'b0;
							end
						end
					end
				end
				PG_HOLD: begin
					if (!req || is_level || is_cont)
						st_r <= PG_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: verilog/spsa_ctrl.sv
// Top of the reference pulse, sync trigger, beat timer and alarm control block
// Contract
// - Burst code 000 runs pulses while a request is held, stops when removed.
// - Pulse requests come from general input, register command, or sync pin.
// - Codes 001 to 110 give bursts of 1, 2, 4, 8, 16, 16 pulses.
// - Code 111 gives continuous pulses at half duty.
// - Realign bit set aligns sync trigger to internal beat; clear bypasses it.
// - Polarity bit 0 is positive trigger, 1 negative; software keeps 0 off-primary.
// - Beat setpoint low byte in first register, high nibble in next.
// - Beat timer counting to setpoint paces sync and pulse events.
// - Halving bit divides the incoming reference by two before distribution.
// - Mask bit 4 lets sync request status reach the alarm.
// - Mask bit 2 lets output phase status reach the alarm.
// - Mask bit 1 lets reference sync status reach the alarm.
// - Read-only 24-bit identifier over three bytes, low, mid, high.
// - Delay low-power bit allows glitchy setpoint changes; clear keeps them glitch-free.
// - Combined alarm readable at bit 0 of alarm readback register.
// - Reference sync status reads 1 until first sync, then 0.
`timescale 1ns/1ps
`default_nettype none
`include "spsa_params.svh"
module spsa_ctrl #(
	// Arbitrary neutral identifier value
	parameter logic [23:0] PART_ID = 24'h5a3c01
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk_i,
	input wire logic sen_n_i,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe,
	input wire logic sync_pin_i,
	input wire logic gpi_i,
	input wire logic gpi_pulse_sel_i,
	input wire logic reg_pulse_req_i,
	input wire logic reg_sync_req_i,
	input wire logic sync_pin_as_pulse_i,
	input wire logic phase_stable_i,
	output logic sysref_o,
	output logic pulse_busy_o,
	output logic beat_o,
	output logic sync_restart_o,
	output logic alarm_o,
	output logic halve_en_o,
	output logic half_phase_o,
	output logic lowfreq_bias_o,
	output logic delay_lowpower_o
);
	import spsa_pkg::*;
	// Reset words held as typed constants so single fields can be selected from them
	localparam logic [7:0] RST_TRIG = `SPSA_RST_TRIG;
	localparam logic [11:0] RST_BEAT = `SPSA_RST_BEAT;
	localparam logic [7:0] RST_BYTE = `SPSA_RST_BYTE;

	// ****************************************
	// Register file
	// ****************************************
	spsa_reg_if rif ();
	spsa_burst_sel_t mode_r;
	logic realign_r;
	logic polarity_r;
	logic [7:0] beat_lo_r;
	logic [3:0] beat_hi_r;
	logic halve_r;
	logic lowfreq_r;
	logic dly_lp_r;
	logic mask_syncreq_r;
	logic mask_phase_r;
	logic mask_align_r;
	wire hit_pulse = (rif.addr == `SPSA_OFF_PULSE);
	wire hit_trig = (rif.addr == `SPSA_OFF_TRIG);
	wire hit_beat_lo = (rif.addr == `SPSA_OFF_BEAT_LO);
	wire hit_beat_hi = (rif.addr == `SPSA_OFF_BEAT_HI);
	wire hit_input = (rif.addr == `SPSA_OFF_INPUT);
	wire hit_delay = (rif.addr == `SPSA_OFF_DELAY);
	wire hit_mask = (rif.addr == `SPSA_OFF_MASK);
	wire [7:0] wd = rif.wdata;

	spsa_serial_port u_port (
		.clk(clk),
		.rst_n(rst_n),
		.sclk_i(sclk_i),
		.sen_n_i(sen_n_i),
		.sdio_i(sdio_i),
		.sdio_o(sdio_o),
		.sdio_oe(sdio_oe),
		.bus(rif.port)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_r <= `SPSA_RST_MODE;
			realign_r <= RST_TRIG[`SPSA_BIT_REALIGN];
			polarity_r <= RST_TRIG[`SPSA_BIT_POLARITY];
			beat_lo_r <= RST_BEAT[7:0];
			beat_hi_r <= RST_BEAT[11:8];
		end else if (rif.wr) begin
			if (hit_pulse)
				mode_r <= wd[2:0];
			if (hit_trig) begin
				realign_r <= wd[`SPSA_BIT_REALIGN];
				polarity_r <= wd[`SPSA_BIT_POLARITY];
			end
			if (hit_beat_lo)
				beat_lo_r <= wd[7:0];
			if (hit_beat_hi)
				beat_hi_r <= wd[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			halve_r <= RST_BYTE[`SPSA_BIT_HALVE];
			lowfreq_r <= RST_BYTE[`SPSA_BIT_LOWFREQ];
			dly_lp_r <= RST_BYTE[`SPSA_BIT_DLY_LP];
			mask_syncreq_r <= RST_BYTE[`SPSA_BIT_M_SYNCREQ];
			mask_phase_r <= RST_BYTE[`SPSA_BIT_M_PHASE];
			mask_align_r <= RST_BYTE[`SPSA_BIT_M_ALIGN];
		end else if (rif.wr) begin
			if (hit_input) begin
				halve_r <= wd[`SPSA_BIT_HALVE];
				lowfreq_r <= wd[`SPSA_BIT_LOWFREQ];
			end
			if (hit_delay)
				dly_lp_r <= wd[`SPSA_BIT_DLY_LP];
			if (hit_mask) begin
				mask_syncreq_r <= wd[`SPSA_BIT_M_SYNCREQ];
				mask_phase_r <= wd[`SPSA_BIT_M_PHASE];
				mask_align_r <= wd[`SPSA_BIT_M_ALIGN];
			end
		end
	end

	// ****************************************
	// Input halving and distributed step
	// ****************************************
	// The distributed step marks every second clock while halving, keeping one clock domain
	logic half_r;
	wire dist_step = ~halve_r | half_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			half_r <= 1'b0;
			halve_en_o <= 1'b0;
			half_phase_o <= 1'b0;
		end else begin
			half_r <= halve_r & ~half_r;
			halve_en_o <= halve_r;
			half_phase_o <= halve_r & ~half_r;
		end
	end

	// ****************************************
	// Master beat timer
	// ****************************************
	spsa_beat_t beat_cnt_r;
	logic beat_r;
	wire spsa_beat_t beat_set = {beat_hi_r, beat_lo_r};
	wire beat_wrap = dist_step & (beat_cnt_r >= beat_set);

	// A setpoint lowered below the count wraps at once instead of rolling over 4096 steps
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			beat_cnt_r <= 12'h000;
			beat_r <= 1'b0;
			beat_o <= 1'b0;
		end else begin
			beat_r <= beat_wrap;
			beat_o <= beat_wrap;
			if (beat_wrap)
				beat_cnt_r <= 12'h000;
			else if (dist_step)
				beat_cnt_r <= beat_cnt_r + 12'h001;
		end
	end

	// ****************************************
	// External trigger and general input
	// ****************************************
	logic trig_s1_r;
	logic trig_s2_r;
	logic trig_d_r;
	logic gpi_s1_r;
	logic gpi_s2_r;
	logic reg_sync_d_r;
	wire trig_lvl = trig_s2_r ^ polarity_r;
	wire trig_rise = trig_lvl & ~trig_d_r;
	wire reg_sync_rise = reg_sync_req_i & ~reg_sync_d_r;

	always_ff @(posedge clk) begin
		trig_s1_r <= sync_pin_i;
		trig_s2_r <= trig_s1_r;
		gpi_s1_r <= gpi_i;
		gpi_s2_r <= gpi_s1_r;
		trig_d_r <= trig_lvl;
		reg_sync_d_r <= reg_sync_req_i;
		if (!rst_n) begin
			trig_s1_r <= 1'b0;
			trig_s2_r <= 1'b0;
			gpi_s1_r <= 1'b0;
			gpi_s2_r <= 1'b0;
			trig_d_r <= 1'b0;
			reg_sync_d_r <= 1'b0;
		end
	end

	// ****************************************
	// Sync request scheduling
	// ****************************************
	// Pin edges feed the sync path unless the pin is assigned to the pulse generator
	wire sync_event = (trig_rise & ~sync_pin_as_pulse_i) | reg_sync_rise;
	logic sync_pend_r;
	logic unsync_r;
	// Realigned events wait for the beat; bypassed ones act at once with pin-dependent timing
	// A request left pending when realign is switched off is served at once, never stuck
	wire sync_serve = realign_r ? (sync_pend_r & beat_r) : (sync_event | sync_pend_r);
	wire sync_pend_nxt = (sync_event & realign_r) | (sync_pend_r & ~sync_serve);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_pend_r <= 1'b0;
			unsync_r <= 1'b1;
			sync_restart_o <= 1'b0;
		end else begin
			sync_pend_r <= sync_pend_nxt;
			sync_restart_o <= sync_serve;
			if (sync_serve)
				unsync_r <= 1'b0;
		end
	end

	// ****************************************
	// Pulse generator
	// ****************************************
	wire pg_req_gpi = gpi_pulse_sel_i & gpi_s2_r;
	wire pg_req_pin = sync_pin_as_pulse_i & trig_lvl;
	wire pg_req = pg_req_gpi | reg_pulse_req_i | pg_req_pin;

	spsa_pulse_gen u_pg (
		.clk(clk),
		.rst_n(rst_n),
		.beat(beat_r),
		.mode(mode_r),
		.req(pg_req),
		.pulse_o(sysref_o),
		.busy_o(pulse_busy_o)
	);

	// ****************************************
	// Alarm
	// ****************************************
	// Phase status is active when unstable, so its source is the inverse of stable
	wire src_syncreq = mask_syncreq_r & sync_pend_r;
	wire src_phase = mask_phase_r & ~phase_stable_i;
	wire src_align = mask_align_r & unsync_r;
	wire alarm_nxt = src_syncreq | src_phase | src_align;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alarm_o <= 1'b0;
			lowfreq_bias_o <= 1'b0;
			delay_lowpower_o <= 1'b0;
		end else begin
			alarm_o <= alarm_nxt;
			lowfreq_bias_o <= lowfreq_r;
			// Delay stage may glitch between setpoints while this is set
			delay_lowpower_o <= dly_lp_r;
		end
	end

	// ****************************************
	// Read back
	// ****************************************
	wire [7:0] rd_pulse = {5'h00, mode_r};
	wire [7:0] rd_trig = {5'h00, realign_r, 1'b0, polarity_r};
	wire [7:0] rd_beat_hi = {4'h0, beat_hi_r};
	wire [7:0] rd_input = {6'h00, halve_r, lowfreq_r};
	wire [7:0] rd_delay = {7'h00, dly_lp_r};
	wire [7:0] rd_mask = {3'h0, mask_syncreq_r, 1'b0, mask_phase_r, mask_align_r, 1'b0};
	wire [7:0] rd_alarm = {7'h00, alarm_o};
	wire [7:0] rd_status = {3'h0, sync_pend_r, 1'b0, phase_stable_i, unsync_r, 1'b0};
	wire [7:0] rd_id = (rif.addr == `SPSA_OFF_ID_LO) ? PART_ID[7:0] :
		(rif.addr == `SPSA_OFF_ID_MID) ? PART_ID[15:8] : PART_ID[23:16];
	wire hit_id = (rif.addr == `SPSA_OFF_ID_LO) | (rif.addr == `SPSA_OFF_ID_MID) |
		(rif.addr == `SPSA_OFF_ID_HI);

	assign rif.rdata = hit_pulse ? rd_pulse :
		hit_trig ? rd_trig :
		hit_beat_lo ? beat_lo_r :
		hit_beat_hi ? rd_beat_hi :
		hit_input ? rd_input :
		hit_delay ? rd_delay :
		hit_mask ? rd_mask :
		hit_id ? rd_id :
		(rif.addr == `SPSA_OFF_ALARM_RB) ? rd_alarm :
		(rif.addr == `SPSA_OFF_STATUS_RB) ? rd_status : 8'h00;
endmodule
`default_nettype wire

// File: verification/spsa_host_model.sv
// Serial host model for the three-wire control port
`timescale 1ns/1ps
`default_nettype none
module spsa_host_model (
	input wire logic clk,
	output logic sclk,
	output logic sen_n,
	output logic sdio,
	input wire logic dev_sdio,
	input wire logic dev_oe
);
	// ****************
	// Frame driver
	// ****************
	logic host_d;
	// Released line shows the inverse of the last bit, so a stale value never passes
	assign sdio = dev_oe ? dev_sdio : host_d;
	initial begin
		sclk = 1'b0;
		sen_n = 1'b1;
		host_d = 1'b0;
	end
	task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] q);
		logic [23:0] f;
		f = {rd, 2'b00, a, wd};
		q = 8'h00;
		sen_n = 1'b0;
		repeat (5) @(negedge clk);
		// Half periods of 5 clocks leave the port's two-flop sampling time to settle
		for (int i = 23; i >= 0; i--) begin
			host_d = (rd && i < 8) ? ~host_d : f[i];
			repeat (5) @(negedge clk);
			if (i < 8)
				q[i] = sdio;
			sclk = 1'b1;
			repeat (5) @(negedge clk);
			sclk = 1'b0;
		end
		repeat (2) @(negedge clk);
		sen_n = 1'b1;
		repeat (6) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// File: verification/spsa_ctrl_monitor.sv
// Concurrent checks on the ports of the reference pulse control block
`timescale 1ns/1ps
`default_nettype none
module spsa_ctrl_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk_i,
	input wire logic sen_n_i,
	input wire logic sdio_o,
	input wire logic sdio_oe,
	input wire logic sysref_o,
	input wire logic pulse_busy_o,
	input wire logic beat_o,
	input wire logic sync_restart_o,
	input wire logic alarm_o
);
	// ****************
	// Port relations, valid while the setpoint stays at 9 or more
	// ****************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	chk_beat_gap: assert property (beat_o |=> !beat_o [*8])
		else $error("beat pulses too close");
	chk_restart_single: assert property (sync_restart_o |=> !sync_restart_o)
		else $error("sync restart longer than one cycle");
	chk_pulse_high: assert property ($rose(sysref_o) |=> sysref_o [*8])
		else $error("pulse high phase shorter than a beat");
	chk_pulse_low: assert property ($fell(sysref_o) |=> !sysref_o [*8])
		else $error("pulse low phase shorter than a beat");
	chk_burst_end_low: assert property ($fell(pulse_busy_o) |-> !sysref_o)
		else $error("burst ended with pulse high");
	chk_reset_quiet: assert property ($rose(rst_n) |-> !sysref_o && !alarm_o && !pulse_busy_o)
		else $error("outputs active after reset");
	chk_oe_release: assert property ($rose(sen_n_i) |-> ##[0:4] !sdio_oe)
		else $error("data line held after frame end");
	chk_sdio_stands: assert property (sdio_oe && $past(sdio_oe) && $changed(sdio_o) |-> !sclk_i)
		else $error("read bit changed while serial clock high");
endmodule
bind spsa_ctrl spsa_ctrl_monitor i_mon (.clk(clk), .rst_n(rst_n), .sclk_i(sclk_i), .sen_n_i(sen_n_i),
	.sdio_o(sdio_o), .sdio_oe(sdio_oe), .sysref_o(sysref_o), .pulse_busy_o(pulse_busy_o), .beat_o(beat_o),
	.sync_restart_o(sync_restart_o), .alarm_o(alarm_o));
`default_nettype wire

// File: verification/spsa_ctrl_tb.sv
// Self-checking testbench of the reference pulse control block
`timescale 1ns/1ps
`default_nettype none
module spsa_ctrl_tb;
	import spsa_pkg::*;
	// ****************
	// Bench
	// ****************
	localparam logic [23:0] ID = 24'h3c5a96; // Arbitrary value
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sclk, sen_n, sdio, sync_pin, gpi, gpi_sel, preq, sreq, pin_pulse, phs;
	logic sdio_o, sdio_oe, sysref, busy, beat, restart, alarm, halve, hph, lfb, dlp, sref_q;
	logic [31:0] lfsr = 32'h96f2;
	logic [7:0] q, d;
	logic [12:0] offs [11] = '{13'h5a, 13'h5b, 13'h5c, 13'h5d, 13'h64, 13'h65, 13'h71, 13'h78, 13'h79, 13'h7a, 13'h60};
	logic [7:0] rstv [11] = '{8'h00, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, ID[7:0], ID[15:8], ID[23:16], 8'h00};
	int mismatches = 0;
	int num_checks = 0;
	int rises = 0;
	int restarts = 0;
	int bph = 0;
	int sp, n, r0, r1, ph;
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		sref_q <= sysref;
		rises <= rises + int'(sysref && !sref_q);
		restarts <= restarts + int'(restart);
		bph <= beat ? 0 : bph + 1;
	end
	spsa_ctrl #(.PART_ID(ID)) i_dut (.clk(clk), .rst_n(rst_n), .sclk_i(sclk), .sen_n_i(sen_n), .sdio_i(sdio),
		.sdio_o(sdio_o), .sdio_oe(sdio_oe), .sync_pin_i(sync_pin), .gpi_i(gpi), .gpi_pulse_sel_i(gpi_sel),
		.reg_pulse_req_i(preq), .reg_sync_req_i(sreq), .sync_pin_as_pulse_i(pin_pulse), .phase_stable_i(phs),
		.sysref_o(sysref), .pulse_busy_o(busy), .beat_o(beat), .sync_restart_o(restart), .alarm_o(alarm),
		.halve_en_o(halve), .half_phase_o(hph), .lowfreq_bias_o(lfb), .delay_lowpower_o(dlp));
	spsa_host_model i_host (.clk(clk), .sclk(sclk), .sen_n(sen_n), .sdio(sdio), .dev_sdio(sdio_o), .dev_oe(sdio_oe));
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic int burst_len(input logic [2:0] c);
		return (c == 3'h6) ? 16 : (1 << (c - 1));
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] v);
		i_host.xfer(1'b0, a, v, q);
	endtask
	task automatic rd(input logic [12:0] a);
		i_host.xfer(1'b1, a, 8'h00, q);
	endtask
	// Bounded waits; wait_restart and period give back a cycle count for latency and period checks
	task automatic wait_beat();
		for (int k = 0; beat !== 1'b1 && k < 9000; k++)
			@(negedge clk);
		@(negedge clk);
	endtask
	task automatic wait_restart(output int k);
		for (k = 0; restart !== 1'b1 && k < 9000; k++)
			@(negedge clk);
	endtask
	task automatic period(output int k);
		time t0;
		wait_beat();
		t0 = $time;
		wait_beat();
		k = int'(($time - t0) / 25);
	endtask
	initial begin
		#(25 * 80000);
		mismatches++;
		conclude();
	end
	initial begin
		{sync_pin, gpi, gpi_sel, preq, sreq, pin_pulse, phs} = 7'h01;
		cyc(20);
		rst_n = 1'b1;
		cyc(4);
		foreach (offs[i]) begin
			rd(offs[i]);
			check(q, rstv[i], "reset value");
		end
		wr(13'h78, lfsr[7:0]);
		rd(13'h78);
		check(q, ID[7:0], "identifier write ignored");
		rd(13'h7d);
		check(q, 8'h06, "status after reset");
		wr(13'h71, 8'h02);
		check(alarm, 1'b1, "unsynced alarm");
		rd(13'h7b);
		check(q, 8'h01, "alarm readback");
		wr(13'h71, 8'h04);
		phs = 1'b0;
		cyc(3);
		check(alarm, 1'b1, "phase alarm");
		phs = 1'b1;
		cyc(3);
		check(alarm, 1'b0, "alarm clear");
		$display("test registers and alarm done");
		for (int i = 0; i < 3; i++) begin
			lfsr = nxt(lfsr);
			d = lfsr[7:0];
			wr(13'h65, d);
			check(dlp, d[0], "delay low power");
			wr(13'h64, d);
			check({halve, lfb}, d[1:0], "input path bits");
			rd(13'h64);
			check(q, {6'h00, d[1:0]}, "input path readback");
		end
		wr(13'h64, 8'h00);
		sp = 9 + int'(lfsr[12:8]);
		wr(13'h5c, 8'(sp));
		wr(13'h5d, 8'hf0);
		period(n);
		check(n, sp + 1, "beat period");
		wr(13'h5d, 8'h01);
		period(n);
		check(n, 257 + sp, "beat high nibble");
		wr(13'h5d, 8'h00);
		wr(13'h64, 8'h02);
		period(n);
		check(n, 2 * (sp + 1), "halved beat");
		ph = int'(hph);
		cyc(1);
		check(hph, 1'(1 - ph), "half phase toggles");
		wr(13'h64, 8'h00);
		$display("test beat done");
		// Each source in turn: general input, sync pin and command
		{gpi_sel, pin_pulse} = 2'b11;
		for (int c = 1; c < 7; c++) begin
			wr(13'h5a, 8'(c));
			r0 = rises;
			case (c % 3)
				0: preq = 1'b1;
				1: gpi = 1'b1;
				default: sync_pin = 1'b1;
			endcase
			cyc(4);
			check(busy, 1'b1, "burst busy");
			{preq, gpi, sync_pin} = 3'b000;
			cyc(40 * (sp + 1));
			check(rises - r0, burst_len(3'(c)), "burst count");
			check(busy, 1'b0, "burst done");
			check(sysref, 1'b0, "burst ends low");
		end
		{gpi_sel, pin_pulse} = 2'b00;
		wr(13'h5a, 8'h00);
		r0 = rises;
		preq = 1'b1;
		cyc(9 * (sp + 1));
		preq = 1'b0;
		cyc(4 * (sp + 1));
		r1 = rises;
		cyc(6 * (sp + 1));
		check(r1 - r0 > 2, 1'b1, "level mode ran");
		check(rises, r1, "level mode stopped");
		wr(13'h5a, 8'h07);
		cyc(2 * (sp + 1));
		r0 = rises;
		cyc(20 * (sp + 1));
		check(rises - r0, 10, "continuous pulses");
		wr(13'h5a, 8'h00);
		$display("test pulse generator done");
		wr(13'h71, 8'h10);
		wait_beat();
		sync_pin = 1'b1;
		cyc(6);
		check(alarm, 1'b1, "pending sync alarm");
		wait_restart(n);
		ph = bph;
		cyc(3);
		check(alarm, 1'b0, "pending served");
		rd(13'h7d);
		check(q, 8'h04, "synced status");
		wr(13'h5b, 8'h05);
		wait_beat();
		sync_pin = 1'b0;
		wait_restart(n);
		check(bph, ph, "realigned phase");
		wr(13'h5b, 8'h01);
		r0 = restarts;
		sync_pin = 1'b1;
		cyc(8);
		check(restarts, r0, "inactive edge ignored");
		wait_beat();
		sync_pin = 1'b0;
		wait_restart(n);
		check(n < 7, 1'b1, "bypass latency");
		cyc(4);
		r0 = restarts;
		sreq = 1'b1;
		cyc(8);
		sreq = 1'b0;
		check(restarts - r0, 1, "register sync");
		$display("test sync done");
		conclude();
	end
endmodule
`default_nettype wire
